// *** rtl/fbhc_pkg.sv ***
/*
  Constants shared by the flash host controller: pin timing figures, derived
  cycle counts, sector map boundaries and the controller state encoding.
  Assumes a 50 MHz core clock and an asynchronous parallel flash on the pins.
*/
package fbhc_pkg;

  // Clock period in picoseconds.
  localparam int CLK_PERIOD_PS = 20000;

  // Pin timing figures in nanoseconds; device speed grades may differ.
  localparam int RESET_PULSE_MIN_TIME_NS     = 500;
  localparam int RESET_HIGH_TO_READ_TIME_NS  = 50;
  localparam int ADDRESS_TO_OUTPUT_TIME_NS   = 90;
  localparam int SELECT_TO_OUTPUT_TIME_NS    = 90;
  localparam int READY_EMBEDDED_TIME_NS      = 20000;
  localparam int WRITE_PULSE_TIME_NS         = 35;
  localparam int SLEEP_EXTRA_TIME_NS         = 30;

  // Least times round up to whole cycles.
  function automatic int ns_to_cycles_up(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RESET_PULSE_CYCLES    = ns_to_cycles_up(RESET_PULSE_MIN_TIME_NS);
  localparam int RESET_TO_READ_CYCLES  = ns_to_cycles_up(RESET_HIGH_TO_READ_TIME_NS);
  localparam int ADDR_ACCESS_CYCLES    = ns_to_cycles_up(ADDRESS_TO_OUTPUT_TIME_NS);
  localparam int SELECT_ACCESS_CYCLES  = ns_to_cycles_up(SELECT_TO_OUTPUT_TIME_NS);
  localparam int READY_WAIT_CYCLES     = ns_to_cycles_up(READY_EMBEDDED_TIME_NS);
  localparam int WRITE_PULSE_CYCLES    = ns_to_cycles_up(WRITE_PULSE_TIME_NS);
  localparam int SLEEP_AFTER_CYCLES    =
    ns_to_cycles_up(ADDRESS_TO_OUTPUT_TIME_NS + SLEEP_EXTRA_TIME_NS);

  localparam int TIMER_W = 16;

  // Sector map of the top-boot part.
  localparam logic [4:0] TOP_GROUP       = 5'h1F;
  localparam logic [5:0] SECT_HALF_TOP   = 6'h1F;
  localparam logic [5:0] SECT_SMALL_A    = 6'h20;
  localparam logic [5:0] SECT_SMALL_B    = 6'h21;
  localparam logic [5:0] SECT_BOOT       = 6'h22;
  localparam logic [2:0] SMALL_A_CODE    = 3'h4;
  localparam logic [2:0] SMALL_B_CODE    = 3'h5;

  // Controller states, Gray coded along reset-recov-idle-read path.
  typedef enum logic [2:0] {
    FBHC_RESET = 3'h0,
    FBHC_RECOV = 3'h1,
    FBHC_IDLE  = 3'h3,
    FBHC_READ  = 3'h2,
    FBHC_WRITE = 3'h6,
    FBHC_DONE  = 3'h7
  } fbhc_state_e;

endpackage

// *** rtl/fbhc_sector_decode.sv ***
/*
  Top-boot sector index decoder: turns a word address into a six-bit index.
  Assumes the word address bits A19..A12 sit at the top of the input.
*/
`timescale 1ns/1ps
module fbhc_sector_decode
  import fbhc_pkg::*;
(
  input  wire logic [19:0] wordAddr,   // Word address A19..A0.
  output logic      [5:0]  sectorIdx   // Sector index 0 to 34.
);
  import fbhc_pkg::*;

  // Large sectors use A19..A15 directly; the top group splits into four.
  always_comb begin
    if (wordAddr[19:15] != TOP_GROUP) begin
      sectorIdx = {1'b0, wordAddr[19:15]};                           // [R15] [R18]
    end else if (!wordAddr[14]) begin
      sectorIdx = SECT_HALF_TOP;                                     // [R15]
    end else if (wordAddr[14:12] == SMALL_A_CODE) begin
      sectorIdx = SECT_SMALL_A;                                      // [R15]
    end else if (wordAddr[14:12] == SMALL_B_CODE) begin
      sectorIdx = SECT_SMALL_B;                                      // [R15]
    end else begin
      sectorIdx = SECT_BOOT;                                         // [R15]
    end
  end

endmodule

// *** rtl/fbhc_host.sv ***
/*
  Host-side controller for an asynchronous parallel boot-sector flash.
  Drives select, output enable, write enable, reset and the data pins, times
  every access in core clock cycles, and reports the sector of each address.
  Assumes pins are sampled synchronously and the flash is a top-boot part.
*/
// Function
// [R1] Poll status with ordinary read cycles.
// [R2] Device floats data in standby.
// [R3] Standby when select and reset high idle.
// [R4] Wait select access time before sampling.
// [R5] Device finishes operation when deselected.
// [R6] Device sleeps after stable address.
// [R7] Sleep keeps data; new address normal timing.
// [R8] Reset pulse aborts, floats, ignores accesses.
// [R9] Reset returns device to array read.
// [R10] Host reissues operations interrupted by reset.
// [R11] Busy held low during embedded reset.
// [R12] Non-embedded reset finishes faster.
// [R13] Wait reset-to-read delay after reset.
// [R14] Output enable high floats outputs.
// [R15] Top-boot sector map decode.
// [R16] Width pin selects word or byte.
// [R17] Array read after reset, no command.
// [R18] Six-bit sector index from address.
`timescale 1ns/1ps
module fbhc_host
  import fbhc_pkg::*;
#(
  parameter int RESET_CYCLES = RESET_PULSE_CYCLES,   // Reset pulse length.
  parameter int READY_CYCLES = READY_WAIT_CYCLES     // Longest busy wait.
)(
  input  wire logic                core_clk,       // Core clock, 50 MHz.
  input  wire logic                rstn,           // Asynchronous reset, low.
  input  wire logic                reqValid,       // Request strobe.
  input  wire logic                reqWrite,       // 1 write, 0 read.
  input  wire logic [20:0]         reqAddr,        // Byte address A19..A-1.
  input  wire logic [15:0]         reqWdata,       // Write data.
  input  wire logic                wordMode,       // 1 word, 0 byte.
  input  wire logic                resetReq,       // Start hardware reset.
  output logic                     reqReady_ff,    // Idle, request accepted.
  output logic                     rspValid_ff,    // Read or write done pulse.
  output logic [15:0]              rspData_ff,     // Read data.
  output logic [5:0]               rspSector_ff,   // Sector of last access.
  output logic                     resetAbort_ff,  // Reset cut a busy op.
  output logic                     chipSel_n_ff,   // Chip select, low.
  output logic                     outEn_n_ff,     // Output enable, low.
  output logic                     wrEn_n_ff,      // Write enable, low.
  output logic                     devReset_n_ff,  // Device reset, low.
  output logic                     width_ff,       // Width select pin.
  output logic [19:0]              addrPins_ff,    // Address A19..A0.
  output logic [15:0]              dataOut_ff,     // Data pin output.
  output logic                     dataOe_ff,      // Data pin enable.
  input  wire logic [15:0]         dataIn,         // Data pin input.
  input  wire logic                ready_busy_n    // Device ready, busy low.
);
  import fbhc_pkg::*;

  initial begin
    if (RESET_CYCLES < 1 || RESET_CYCLES >= (1 << TIMER_W) ||
        READY_CYCLES < 1 || READY_CYCLES >= (1 << TIMER_W) ||
        READY_CYCLES <= RESET_TO_READ_CYCLES) begin
      $error("fbhc_host: cycle counts out of range");
    end
  end

  localparam logic [TIMER_W-1:0] T_RESET = TIMER_W'(RESET_CYCLES);
  localparam logic [TIMER_W-1:0] T_READY = TIMER_W'(READY_CYCLES);
  localparam logic [TIMER_W-1:0] T_RTR   = TIMER_W'(RESET_TO_READ_CYCLES);
  localparam logic [TIMER_W-1:0] T_SEL   = TIMER_W'(SELECT_ACCESS_CYCLES);
  localparam logic [TIMER_W-1:0] T_WR    = TIMER_W'(WRITE_PULSE_CYCLES);
  localparam logic [TIMER_W-1:0] T_ZERO  = '0;
  localparam logic [TIMER_W-1:0] T_ONE   = TIMER_W'(1);

  fbhc_state_e            state_ff;
  fbhc_state_e            nxt_state;
  logic [TIMER_W-1:0]     timer_ff;
  logic [TIMER_W-1:0]     nxt_timer;
  logic                   opWrite_ff;
  logic [5:0]             sectorIdx;
  logic [19:0]            nxtAddr;
  logic                   timerDone;

  assign timerDone = (timer_ff == T_ZERO);

  // In byte mode A-1 leaves on data pin 15 when writing, so the address pins take A19..A0.
  assign nxtAddr = reqAddr[20:1];

  fbhc_sector_decode u_decode (
    .wordAddr  (nxtAddr),
    .sectorIdx (sectorIdx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing. Reset waits for busy to rise, bounded so a stuck pin cannot
  // hang the controller forever.
  always_comb begin
    nxt_state = state_ff;
    nxt_timer = timerDone ? T_ZERO : timer_ff - T_ONE;
    case (state_ff)
      FBHC_RESET: begin
        if (timerDone) begin
          nxt_state = FBHC_RECOV;                                    // [R8]
          nxt_timer = T_READY;
        end
      end
      FBHC_RECOV: begin
        if (ready_busy_n && timer_ff <= T_READY - T_RTR) begin
          nxt_state = FBHC_IDLE;                                     // [R11] [R12] [R13]
        end else if (timerDone) begin
          nxt_state = FBHC_IDLE;
        end
      end
      FBHC_IDLE: begin
        if (resetReq) begin
          nxt_state = FBHC_RESET;
          nxt_timer = T_RESET;
        end else if (reqValid) begin
          nxt_state = reqWrite ? FBHC_WRITE : FBHC_READ;
          nxt_timer = reqWrite ? T_WR : T_SEL;                       // [R4]
        end
      end
      FBHC_READ, FBHC_WRITE: begin
        if (timerDone) begin
          nxt_state = FBHC_DONE;
        end
      end
      FBHC_DONE: nxt_state = FBHC_IDLE;
      default:   nxt_state = FBHC_IDLE;
    endcase
  end

  // State and timer registers.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= FBHC_RESET;
      timer_ff <= T_RESET;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device pin drive. Select and reset rest high in idle so the device can
  // drop to standby; the device keeps running a busy operation anyway.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      chipSel_n_ff  <= 1'b1;
      outEn_n_ff    <= 1'b1;
      wrEn_n_ff     <= 1'b1;
      devReset_n_ff <= 1'b0;
      dataOe_ff     <= 1'b0;
    end else begin
      devReset_n_ff <= (nxt_state != FBHC_RESET);                    // [R8] [R9] [R17]
      chipSel_n_ff  <= !(nxt_state == FBHC_READ || nxt_state == FBHC_WRITE); // [R3] [R5]
      outEn_n_ff    <= (nxt_state != FBHC_READ);                     // [R14] [R2]
      wrEn_n_ff     <= !(nxt_state == FBHC_WRITE && !nxt_timer[TIMER_W-1] &&
                         state_ff == FBHC_IDLE) && !(state_ff == FBHC_WRITE && !timerDone);
      dataOe_ff     <= (nxt_state == FBHC_WRITE);
    end
  end

  // Address, width and write data latch on acceptance; held afterwards,
  // which also keeps the device's sleeping output stable.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      addrPins_ff  <= '0;
      dataOut_ff   <= '0;
      width_ff     <= 1'b1;
      opWrite_ff   <= 1'b0;
      rspSector_ff <= '0;
    end else if (state_ff == FBHC_IDLE && reqValid && !resetReq) begin
      addrPins_ff  <= nxtAddr;                                       // [R6] [R7]
      width_ff     <= wordMode;                                      // [R16]
      dataOut_ff   <= wordMode ? reqWdata : {reqAddr[0], 7'h00, reqWdata[7:0]}; // [R16]
      opWrite_ff   <= reqWrite;
      rspSector_ff <= sectorIdx;                                     // [R18]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answers. Read data is sampled only once the select access time is spent;
  // status polling during a busy operation uses the same path.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rspValid_ff <= 1'b0;
      rspData_ff  <= '0;
      reqReady_ff <= 1'b0;
    end else begin
      rspValid_ff <= (nxt_state == FBHC_DONE);
      reqReady_ff <= (nxt_state == FBHC_IDLE);
      if (state_ff == FBHC_READ && timerDone && !opWrite_ff) begin
        rspData_ff <= width_ff ? dataIn : {8'h00, dataIn[7:0]};     // [R1] [R4] [R16]
      end
    end
  end

  // Flags a reset that cut a busy operation so software can reissue it.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      resetAbort_ff <= 1'b0;
    end else if (state_ff == FBHC_IDLE && resetReq) begin
      resetAbort_ff <= !ready_busy_n;                                // [R10]
    end else if (state_ff == FBHC_IDLE && reqValid) begin
      resetAbort_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_reset_pulse;
    !devReset_n_ff [*8];
  endsequence

  chk_reset_pulse_len: assert property (@(posedge core_clk) disable iff (!rstn) // [R8]
    $fell(devReset_n_ff) |-> s_reset_pulse)
    else $error("reset pulse shorter than minimum");

  chk_read_no_write: assert property (@(posedge core_clk) disable iff (!rstn) // [R14]
    !outEn_n_ff |-> wrEn_n_ff && !dataOe_ff)
    else $error("output enable overlaps write drive");

  chk_sel_before_data: assert property (@(posedge core_clk) disable iff (!rstn) // [R4]
    $fell(outEn_n_ff) |-> !rspValid_ff [*4])
    else $error("read answered before select access time");

  chk_no_access_reset: assert property (@(posedge core_clk) disable iff (!rstn) // [R8]
    !devReset_n_ff |-> chipSel_n_ff && outEn_n_ff && wrEn_n_ff)
    else $error("access during device reset");

  chk_idle_standby: assert property (@(posedge core_clk) disable iff (!rstn) // [R3]
    reqReady_ff |-> chipSel_n_ff && devReset_n_ff)
    else $error("idle without standby levels");

  chk_recover_gap: assert property (@(posedge core_clk) disable iff (!rstn) // [R13]
    $rose(devReset_n_ff) |-> chipSel_n_ff [*3])
    else $error("access too soon after reset");

  chk_read_done: assert property (@(posedge core_clk) disable iff (!rstn) // [R1]
    $fell(outEn_n_ff) |-> ##[1:8] rspValid_ff)
    else $error("read did not finish in time");

  chk_sector_range: assert property (@(posedge core_clk) disable iff (!rstn) // [R18]
    rspSector_ff <= SECT_BOOT)
    else $error("sector index out of range");

endmodule

// *** tb/fbhc_flash_model.sv ***
/*
  Behavioural top-boot flash seen from its pins: array data from the address,
  status bytes while a program runs, ready/busy, and reset recovery.
  Assumes the pins are sampled on the host's core clock; no pull on data.
*/
`timescale 1ns/1ps
module fbhc_flash_model
  import fbhc_pkg::*;
#(
  parameter int         BUSY_CYC    = 40,     // Embedded program length.
  parameter int         RECOV_CYC   = 10,     // Reset recovery when busy.
  parameter logic [7:0] STATUS_BYTE = 8'hA5   // Status seen while busy.
)(
  input  wire logic        core_clk,      // Sampling clock.
  input  wire logic        chipSel_n,     // Chip select, low.
  input  wire logic        outEn_n,       // Output enable, low.
  input  wire logic        wrEn_n,        // Write enable, low.
  input  wire logic        devReset_n,    // Reset, low.
  input  wire logic        width,         // 1 word, 0 byte.
  input  wire logic [19:0] addrPins,      // Address A19..A0.
  output logic      [15:0] devData,       // Data driven to the host.
  output logic             ready_busy_n   // Busy low.
);
  logic [15:0] lastOut_ff  = 16'h0000;
  logic [7:0]  busyCnt_ff  = 8'h00;
  logic [3:0]  selCnt_ff   = 4'h0;
  logic        wrEnPrev_ff = 1'b1;
  logic        driving;
  logic [15:0] liveWord;

  // Reset blocks every access; output disable and standby float the pins.
  assign driving  = !chipSel_n && devReset_n && !outEn_n && wrEn_n;
  assign liveWord = (busyCnt_ff != 8'h00) ? {8'h00, STATUS_BYTE}
                                          : (addrPins[15:0] ^ 16'h5A3C);
  assign ready_busy_n = (busyCnt_ff == 8'h00);

  // Data shows only once a full select access time has passed, so a host that
  // samples one cycle early sees the ever-changing guess instead.
  always_comb begin
    devData = ~lastOut_ff;
    if (driving && selCnt_ff >= 4'(SELECT_ACCESS_CYCLES)) begin
      devData = width ? liveWord : {~lastOut_ff[15:8], liveWord[7:0]};
    end
  end

  // Select counter restarts whenever the part leaves standby.
  always_ff @(posedge core_clk) begin
    if (chipSel_n || !devReset_n) begin
      selCnt_ff <= 4'h0;
    end else if (selCnt_ff != 4'hF) begin
      selCnt_ff <= selCnt_ff + 4'h1;
    end
  end

  // Last output value, sampled every cycle whether or not the address moves.
  always_ff @(posedge core_clk) begin
    lastOut_ff <= devData;
  end

  // Program timer: runs on while deselected, cut short by reset.
  always_ff @(posedge core_clk) begin
    wrEnPrev_ff <= wrEn_n;
    if (!devReset_n) begin
      busyCnt_ff <= (busyCnt_ff != 8'h00) ? 8'(RECOV_CYC) : 8'h00;
    end else if (!wrEn_n && wrEnPrev_ff && !chipSel_n) begin
      busyCnt_ff <= 8'(BUSY_CYC);
    end else if (busyCnt_ff != 8'h00) begin
      busyCnt_ff <= busyCnt_ff - 8'h01;
    end
  end
endmodule

// *** tb/fbhc_host_test.sv ***
/*
  Self-checking bench for the flash host controller against the flash model.
  Assumes shortened reset and ready counts and a 50 MHz core clock.
*/
`timescale 1ns/1ps
module fbhc_host_test;
  import fbhc_pkg::*;
  localparam logic [7:0] STATUS_BYTE = 8'hA5;
  logic        core_clk = 1'b0;
  logic        rstn     = 1'b0;
  logic        reqValid = 1'b0;
  logic        reqWrite = 1'b0;
  logic [20:0] reqAddr  = 21'h000000;
  logic [15:0] reqWdata = 16'h0000;
  logic        wordMode = 1'b1;
  logic        resetReq = 1'b0;
  logic        reqReady_ff, rspValid_ff, resetAbort_ff, chipSel_n_ff, outEn_n_ff;
  logic        wrEn_n_ff, devReset_n_ff, width_ff, dataOe_ff, ready_busy_n;
  logic [15:0] rspData_ff, dataOut_ff, dataIn, devData;
  logic [5:0]  rspSector_ff;
  logic [19:0] addrPins_ff;
  logic [15:0] lastWrite  = 16'h0000;
  int          mismatches = 0;
  int          checksDone = 0;
  int          cycles     = 0;

  // Shared data wire: whoever enables drives it.
  assign dataIn = dataOe_ff ? dataOut_ff : devData;

  fbhc_host #(.RESET_CYCLES(8), .READY_CYCLES(20)) i_dut (
    .core_clk(core_clk), .rstn(rstn), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .wordMode(wordMode), .resetReq(resetReq),
    .reqReady_ff(reqReady_ff), .rspValid_ff(rspValid_ff), .rspData_ff(rspData_ff),
    .rspSector_ff(rspSector_ff), .resetAbort_ff(resetAbort_ff),
    .chipSel_n_ff(chipSel_n_ff), .outEn_n_ff(outEn_n_ff), .wrEn_n_ff(wrEn_n_ff),
    .devReset_n_ff(devReset_n_ff), .width_ff(width_ff), .addrPins_ff(addrPins_ff),
    .dataOut_ff(dataOut_ff), .dataOe_ff(dataOe_ff), .dataIn(dataIn),
    .ready_busy_n(ready_busy_n));

  fbhc_flash_model #(.STATUS_BYTE(STATUS_BYTE)) i_flash (
    .core_clk(core_clk), .chipSel_n(chipSel_n_ff), .outEn_n(outEn_n_ff),
    .wrEn_n(wrEn_n_ff), .devReset_n(devReset_n_ff), .width(width_ff),
    .addrPins(addrPins_ff), .devData(devData), .ready_busy_n(ready_busy_n));

  ////////////////////////////////////////////////////////////////////////
  // Clock and a cycle ceiling well above the few hundred cycles needed.
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  // Captures the word the controller drives while write enable is low.
  always @(posedge core_clk) begin
    if (!wrEn_n_ff && dataOe_ff) begin
      lastWrite <= dataOut_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Common tasks.
  task automatic test_done();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits for idle, bounded so a stuck controller cannot hang the run.
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (reqReady_ff !== 1'b1 && n < 200);
    check("reqReady_ff", 16'h0001, {15'h0000, reqReady_ff});
  endtask

  // Waits for the flash to end an embedded program, bounded as well.
  task automatic wait_flash();
    int n;
    n = 0;
    while (ready_busy_n !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    check("ready_busy_n", 16'h0001, {15'h0000, ready_busy_n});
  endtask

  task automatic access(input logic wr, input logic [20:0] addr, input logic [15:0] wd,
                        input logic wm);
    int n;
    wait_ready();
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddr  <= addr;
    reqWdata <= wd;
    wordMode <= wm;
    @(posedge core_clk);
    reqValid <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rspValid_ff !== 1'b1 && n < 50);
    check("rspValid_ff", 16'h0001, {15'h0000, rspValid_ff});
  endtask

  task automatic dev_reset();
    wait_ready();
    resetReq <= 1'b1;
    @(posedge core_clk);
    resetReq <= 1'b0;
    repeat (2) @(posedge core_clk);
    wait_ready();
  endtask

  function automatic logic [15:0] array_word(input logic [20:0] addr);
    return addr[16:1] ^ 16'h5A3C;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_sector_map();
    logic [20:0] mapAddr [9] = '{21'h000000, 21'h010000, 21'h1EFFFF, 21'h1F0000,
                                 21'h1F7FFF, 21'h1F8000, 21'h1F9FFF, 21'h1FA000, 21'h1FFFFF};
    logic [5:0]  mapSect [9] = '{6'h00, 6'h01, 6'h1E, 6'h1F, 6'h1F, 6'h20, 6'h20,
                                 6'h21, 6'h22};
    for (int i = 0; i < 9; i++) begin
      access(1'b0, mapAddr[i], 16'h0000, 1'b1);
      check("rspSector_ff", {10'h000, mapSect[i]}, {10'h000, rspSector_ff});
      check("rspData_ff", array_word(mapAddr[i]), rspData_ff);
    end
  endtask

  // Byte mode: low byte only on reads, A-1 on the top data pin on writes.
  task automatic t_byte_read();
    access(1'b0, 21'h0ABCD3, 16'h0000, 1'b0);
    check("rspData_ff", array_word(21'h0ABCD3) & 16'h00FF, rspData_ff);
    check("width_ff", 16'h0000, {15'h0000, width_ff});
    access(1'b1, 21'h0ABCD3, 16'h00C3, 1'b0);
    check("lastWrite", 16'h80C3, lastWrite);
  endtask

  task automatic t_status_poll();
    access(1'b1, 21'h002000, 16'h1234, 1'b1);
    check("lastWrite", 16'h1234, lastWrite);
    access(1'b0, 21'h002000, 16'h0000, 1'b1);
    check("rspData_ff", {8'h00, STATUS_BYTE}, rspData_ff);
    wait_flash();
    access(1'b0, 21'h002000, 16'h0000, 1'b1);
    check("rspData_ff", array_word(21'h002000), rspData_ff);
  endtask

  task automatic t_reset_busy();
    access(1'b1, 21'h004000, 16'hBEEF, 1'b1);
    dev_reset();
    check("resetAbort_ff", 16'h0001, {15'h0000, resetAbort_ff});
    check("ready_busy_n", 16'h0001, {15'h0000, ready_busy_n});
    access(1'b0, 21'h004000, 16'h0000, 1'b1);
    check("rspData_ff", array_word(21'h004000), rspData_ff);
    access(1'b1, 21'h004000, 16'hBEEF, 1'b1);
    check("lastWrite", 16'hBEEF, lastWrite);
  endtask

  task automatic t_reset_idle();
    wait_flash();
    dev_reset();
    check("resetAbort_ff", 16'h0000, {15'h0000, resetAbort_ff});
  endtask

  // Main sequence: reset for five cycles, then each scenario in turn.
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    t_sector_map();
    t_byte_read();
    t_status_poll();
    t_reset_busy();
    t_reset_idle();
    test_done();
  end
endmodule
